// ### rtl/mei_event_irq.sv
`timescale 1ns/1ps
`default_nettype none
module mei_event_irq
  import mei_pkg::*;
#(
  parameter int NUM_SRC = MEI_NUM_SRC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] link_change_evt,
  input wire logic [1:0] access_complete,
  output logic [1:0] access_go,
  output logic link_irq,
  output logic cmd_irq
);
  // ==========================================================
  // declarations
  mei_reg_if rif ();
  logic [1:0] link_raw_q;
  logic [1:0] link_masked_q;
  logic [1:0] cmd_raw_q;
  logic [1:0] cmd_masked_q;
  logic [1:0] link_en_q;
  logic [1:0] link_en_d;
  logic [1:0] cmd_en_q;
  logic [1:0] cmd_en_d;
  logic [1:0] go_q;
  logic [1:0] go_d;
  logic link_irq_q;
  logic link_irq_d;
  logic cmd_irq_q;
  logic cmd_irq_d;
  logic [1:0] cmd_done;
  logic [1:0] link_set_masked;
  logic [1:0] cmd_set_masked;
  logic [1:0] wr_link_raw;
  logic [1:0] wr_link_masked;
  logic [1:0] wr_cmd_raw;
  logic [1:0] wr_cmd_masked;
  logic [1:0] wr_en_set;
  logic [1:0] wr_en_clear;
  logic [1:0] wr_go;
  logic wr_link_en;

  // ==========================================================
  // address decode helpers
  // one compare shared by write decode, read mux and checks
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    addr_is = (addr == off);
  endfunction

  function automatic logic [1:0] wr_bits(input logic stb, input logic [11:0] addr,
                                         input logic [11:0] off, input logic [1:0] data);
    wr_bits = (stb && addr_is(addr, off)) ? data : 2'h0;
  endfunction

  // ==========================================================
  // bus slave
  mei_apb_slave u_apb (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.bus)
  );

  // ==========================================================
  // write decode, only the low two data bits are kept
  assign wr_link_raw = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_LINK_RAW, rif.wdata);
  assign wr_link_masked = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_LINK_MASKED, rif.wdata);
  assign wr_cmd_raw = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_CMD_RAW, rif.wdata);
  assign wr_cmd_masked = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_CMD_MASKED, rif.wdata);
  assign wr_en_set = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_EN_SET, rif.wdata);
  assign wr_en_clear = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_EN_CLEAR, rif.wdata);
  assign wr_go = wr_bits(rif.wr_stb, rif.addr, MEI_OFF_ACCESS_GO, rif.wdata);
  assign wr_link_en = rif.wr_stb && addr_is(rif.addr, MEI_OFF_LINK_EN);

  // read mux, reserved bits are padded in the bus slave
  always_comb
  begin
    rif.hit = 1'b1;
    rif.rdata = MEI_RESET_BITS;
    if (addr_is(rif.addr, MEI_OFF_LINK_RAW))
      rif.rdata = link_raw_q;
    else if (addr_is(rif.addr, MEI_OFF_LINK_MASKED))
      rif.rdata = link_masked_q;
    else if (addr_is(rif.addr, MEI_OFF_CMD_RAW))
      rif.rdata = cmd_raw_q;
    else if (addr_is(rif.addr, MEI_OFF_CMD_MASKED))
      rif.rdata = cmd_masked_q;
    else if (addr_is(rif.addr, MEI_OFF_EN_SET) || addr_is(rif.addr, MEI_OFF_EN_CLEAR))
      rif.rdata = cmd_en_q;
    else if (addr_is(rif.addr, MEI_OFF_LINK_EN))
      rif.rdata = link_en_q;
    else if (addr_is(rif.addr, MEI_OFF_ACCESS_GO))
      rif.rdata = go_q;
    else
      rif.hit = 1'b0;
  end

  // ==========================================================
  // event qualification
  // completions only count while the request bit is still up
  assign cmd_done = access_complete & go_q;
  assign link_set_masked = link_change_evt & link_en_q;
  assign cmd_set_masked = cmd_done & cmd_en_q;

  // ==========================================================
  // sticky status banks, set wins over a clearing write
  mei_sticky_bits #(.WIDTH(2)) u_link_raw (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_bits(link_change_evt),
    .clr_bits(wr_link_raw),
    .q(link_raw_q)
  );

  mei_sticky_bits #(.WIDTH(2)) u_link_masked (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_bits(link_set_masked),
    .clr_bits(wr_link_masked),
    .q(link_masked_q)
  );

  mei_sticky_bits #(.WIDTH(2)) u_cmd_raw (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_bits(cmd_done),
    .clr_bits(wr_cmd_raw),
    .q(cmd_raw_q)
  );

  mei_sticky_bits #(.WIDTH(2)) u_cmd_masked (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_bits(cmd_set_masked),
    .clr_bits(wr_cmd_masked),
    .q(cmd_masked_q)
  );

  // ==========================================================
  // control registers: enables, request bits, interrupt lines
  always_comb
  begin
    link_en_d = wr_link_en ? rif.wdata : link_en_q;
    cmd_en_d = (cmd_en_q | wr_en_set) & ~wr_en_clear;
    // a busy request bit ignores new writes, so a pending access is not restarted
    go_d = (go_q & ~cmd_done) | (wr_go & ~go_q);
    link_irq_d = |link_masked_q;
    cmd_irq_d = |cmd_masked_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      link_en_q <= MEI_RESET_BITS;
      cmd_en_q <= MEI_RESET_BITS;
      go_q <= MEI_RESET_BITS;
      link_irq_q <= 1'b0;
      cmd_irq_q <= 1'b0;
    end
    else
    begin
      link_en_q <= link_en_d;
      cmd_en_q <= cmd_en_d;
      go_q <= go_d;
      link_irq_q <= link_irq_d;
      cmd_irq_q <= cmd_irq_d;
    end
  end

  assign access_go = go_q;
  assign link_irq = link_irq_q;
  assign cmd_irq = cmd_irq_q;

  // ==========================================================
  // checks on link change events
  a_link_masked_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(link_masked_q[0]) |-> $past(link_change_evt[0]) && $past(link_en_q[0]))
    else $error("masked link bit 0 rose without enabled event");

  a_link_slot_map: assert property (@(posedge sys_clk) disable iff (rst)
    link_change_evt == 2'h2 |=> link_raw_q[1] && (link_raw_q[0] == $past(link_raw_q[0])
      || $past(wr_link_raw[0])))
    else $error("link event on slot 1 disturbed slot 0");

  a_link_w1c: assert property (@(posedge sys_clk) disable iff (rst)
    wr_link_masked[1] && !link_set_masked[1] |=> !link_masked_q[1])
    else $error("masked link bit 1 not cleared by write of one");

  a_link_hold: assert property (@(posedge sys_clk) disable iff (rst)
    link_masked_q[0] && !wr_link_masked[0] |=> link_masked_q[0])
    else $error("masked link bit 0 lost without a clearing write");

  // ==========================================================
  // checks on command completion
  a_done_sets_raw: assert property (@(posedge sys_clk) disable iff (rst)
    go_q[0] && access_complete[0] |=> cmd_raw_q[0] && !go_q[0])
    else $error("completion did not set raw bit and drop request");

  a_raw_w1c: assert property (@(posedge sys_clk) disable iff (rst)
    wr_cmd_raw[1] && !cmd_done[1] |=> !cmd_raw_q[1])
    else $error("raw done bit 1 not cleared");

  a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_done[0] && wr_cmd_raw[0] |=> cmd_raw_q[0])
    else $error("event lost against a clearing write");

  a_masked_needs_en: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cmd_masked_q[1]) |-> $past(cmd_en_q[1]) && $past(cmd_done[1]))
    else $error("masked done bit rose while disabled");

  a_masked_w1c: assert property (@(posedge sys_clk) disable iff (rst)
    wr_cmd_masked[0] && !cmd_set_masked[0] |=> !cmd_masked_q[0])
    else $error("masked done bit 0 not cleared");

  // ==========================================================
  // checks on enable registers and request bits
  a_en_set: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en_set == 2'h3 |=> cmd_en_q == 2'h3)
    else $error("enable set did not enable both slots");

  a_en_set_zero: assert property (@(posedge sys_clk) disable iff (rst)
    rif.wr_stb && addr_is(rif.addr, MEI_OFF_EN_SET) && rif.wdata == 2'h0
      |=> $stable(cmd_en_q))
    else $error("writing zero to enable set changed enables");

  a_en_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en_clear[1] |=> !cmd_en_q[1])
    else $error("enable clear left slot 1 enabled");

  a_go_holds: assert property (@(posedge sys_clk) disable iff (rst)
    go_q[1] && !access_complete[1] |=> go_q[1])
    else $error("request bit dropped before completion");

  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    pready && !pslverr |-> prdata[31:2] == 30'h0)
    else $error("reserved read bits not zero");

  a_irq_or: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 link_irq == $past(|link_masked_q) && cmd_irq == $past(|cmd_masked_q))
    else $error("interrupt line differs from or of masked bits");

  // ==========================================================
  // checks on slot mapping, suppression and the bus answer
  a_link_slot1_raw: assert property (@(posedge sys_clk) disable iff (rst)
    link_change_evt[1] |=> link_raw_q[1])
    else $error("link event on slot 1 did not set raw bit 1");

  a_link_en_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !link_en_q[1] |=> !$rose(link_masked_q[1]))
    else $error("masked link bit 1 rose while its enable was off");

  a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !cmd_en_q[0] |=> !$rose(cmd_masked_q[0]))
    else $error("masked done bit 0 rose while disabled");

  a_done_needs_go: assert property (@(posedge sys_clk) disable iff (rst)
    !go_q[1] |=> !$rose(cmd_raw_q[1]))
    else $error("raw done bit 1 rose without a pending request");

  a_go_self_clear: assert property (@(posedge sys_clk) disable iff (rst)
    go_q[1] && access_complete[1] |=> !go_q[1])
    else $error("request bit 1 did not clear on completion");

  a_irq_holds: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_masked_q != 2'h0 |=> cmd_irq)
    else $error("completion interrupt dropped while a masked bit pends");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");
endmodule
`default_nettype wire

// ### rtl/mei_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the event interrupt block
package mei_pkg;
  // number of monitored phy slots and user access slots
  localparam int MEI_NUM_SRC = 2;
  localparam int MEI_ADDR_W = 12;
  localparam int MEI_DATA_W = 32;
  // register byte offsets
  localparam logic [11:0] MEI_OFF_LINK_RAW = 12'h000;
  localparam logic [11:0] MEI_OFF_LINK_MASKED = 12'h004;
  localparam logic [11:0] MEI_OFF_CMD_RAW = 12'h008;
  localparam logic [11:0] MEI_OFF_CMD_MASKED = 12'h00C;
  localparam logic [11:0] MEI_OFF_EN_SET = 12'h010;
  localparam logic [11:0] MEI_OFF_EN_CLEAR = 12'h014;
  localparam logic [11:0] MEI_OFF_LINK_EN = 12'h018;
  localparam logic [11:0] MEI_OFF_ACCESS_GO = 12'h01C;
  // field position and reset value of every implemented field
  localparam int MEI_FIELD_LSB = 0;
  localparam logic [1:0] MEI_RESET_BITS = 2'h0;
  localparam logic [29:0] MEI_RSVD_READ = 30'h0;
  localparam logic [31:0] MEI_UNMAPPED_READ = 32'h0;
endpackage
`default_nettype wire

// ### rtl/mei_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// register request carrier between bus slave and register bank
interface mei_reg_if;
  logic wr_stb;
  logic [11:0] addr;
  logic [1:0] wdata;
  logic [1:0] rdata;
  logic hit;
  modport bus (output wr_stb, output addr, output wdata, input rdata, input hit);
  modport regs (input wr_stb, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ### rtl/mei_sticky_bits.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sticky event bits, hardware set wins over software clear
module mei_sticky_bits
  import mei_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] bits_q;
  logic [WIDTH-1:0] bits_d;

  // next value: keep, drop cleared, then add new events
  always_comb
  begin
    bits_d = (bits_q & ~clr_bits) | set_bits;
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bits_q <= '0;
    end
    else
    begin
      bits_q <= bits_d;
    end
  end

  assign q = bits_q;
endmodule
`default_nettype wire

// ### rtl/mei_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// apb slave with one wait state, registered answer
module mei_apb_slave
  import mei_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  mei_reg_if.bus rif
);
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic access;

  // request toward the register bank, write only at the ready edge
  assign access = psel & penable;
  assign rif.addr = paddr;
  assign rif.wdata = pwdata[1:0];
  assign rif.wr_stb = access & pready_q & pwrite & rif.hit;

  // answer is prepared in the first access cycle
  always_comb
  begin
    pready_d = access & ~pready_q;
    pslverr_d = access & ~pready_q & ~rif.hit;
    prdata_d = prdata_q;
    if (access & ~pready_q)
    begin
      prdata_d = rif.hit ? {MEI_RSVD_READ, rif.rdata} : MEI_UNMAPPED_READ;
    end
  end

  // answer registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
endmodule
`default_nettype wire

// ### bench/mei_event_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench of the event interrupt block
module mei_event_irq_tb;
  import mei_pkg::*;
  logic sys_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] link_change_evt;
  logic [1:0] access_complete;
  logic [1:0] access_go;
  logic link_irq;
  logic cmd_irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed;
  // reference state of the model
  int lraw, lmsk, craw, cmsk, en, len, go;
  logic [11:0] offs [9];

  // ==========================================================
  // design under test
  mei_event_irq #(.NUM_SRC(MEI_NUM_SRC)) uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_change_evt(link_change_evt),
    .access_complete(access_complete),
    .access_go(access_go),
    .link_irq(link_irq),
    .cmd_irq(cmd_irq)
  );

  // clock and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // reporting
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // ==========================================================
  // register model: read value and write effect
  function automatic int model_rd(input logic [11:0] a);
    case (a)
      MEI_OFF_LINK_RAW: model_rd = lraw;
      MEI_OFF_LINK_MASKED: model_rd = lmsk;
      MEI_OFF_CMD_RAW: model_rd = craw;
      MEI_OFF_CMD_MASKED: model_rd = cmsk;
      MEI_OFF_EN_SET: model_rd = en;
      MEI_OFF_EN_CLEAR: model_rd = en;
      MEI_OFF_LINK_EN: model_rd = len;
      MEI_OFF_ACCESS_GO: model_rd = go;
      default: model_rd = 0;
    endcase
  endfunction

  task automatic model_wr(input logic [11:0] a, input int d);
    d = d & 3;
    case (a)
      MEI_OFF_LINK_RAW: lraw &= ~d;
      MEI_OFF_LINK_MASKED: lmsk &= ~d;
      MEI_OFF_CMD_RAW: craw &= ~d;
      MEI_OFF_CMD_MASKED: cmsk &= ~d;
      MEI_OFF_EN_SET: en |= d;
      MEI_OFF_EN_CLEAR: en &= ~d;
      MEI_OFF_LINK_EN: len = d;
      MEI_OFF_ACCESS_GO: go |= d;
      default: ;
    endcase
  endtask

  // ==========================================================
  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait for the answer however long it takes, the hang guard ends a stall
    do
    begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, err}, {31'h0, (a > MEI_OFF_ACCESS_GO)});
    if (!wr)
      chk(rd, model_rd(a));
    else
      model_wr(a, d);
  endtask

  // one-cycle event pulses, model updated at the sampling edge
  task automatic evt(input logic [1:0] l, input logic [1:0] c);
    int cd;
    @(posedge sys_clk);
    link_change_evt <= l;
    access_complete <= c;
    @(posedge sys_clk);
    cd = c & go;
    lraw |= l;
    lmsk |= l & len;
    craw |= cd;
    cmsk |= cd & en;
    go &= ~cd;
    link_change_evt <= 2'h0;
    access_complete <= 2'h0;
  endtask

  // outputs checked once irq registers have settled
  task automatic chk_out();
    repeat (2) @(posedge sys_clk);
    chk({30'h0, access_go}, go);
    chk({31'h0, link_irq}, lmsk != 0);
    chk({31'h0, cmd_irq}, cmsk != 0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int i;
    int idx;
    logic [31:0] r;
    seed = 32'h4b3f;
    sys_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    link_change_evt = 2'h0;
    access_complete = 2'h0;
    {lraw, lmsk, craw, cmsk, en, len, go} = '0;
    offs = '{MEI_OFF_LINK_RAW, MEI_OFF_LINK_MASKED, MEI_OFF_CMD_RAW, MEI_OFF_CMD_MASKED,
      MEI_OFF_EN_SET, MEI_OFF_EN_CLEAR, MEI_OFF_LINK_EN, MEI_OFF_ACCESS_GO, 12'h020};
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    chk_out();
    chk(prdata, 32'h0);
    chk({30'h0, pready, pslverr}, 32'h0);
    for (i = 0; i < 9; i++)
      apb(1'b0, offs[i], 32'h0);
    // link source: only slot 0 enabled, both slots change
    apb(1'b1, MEI_OFF_LINK_EN, 32'hFFFFFFFD);
    evt(2'h3, 2'h0);
    chk_out();
    apb(1'b0, MEI_OFF_LINK_MASKED, 32'h0);
    apb(1'b1, MEI_OFF_LINK_MASKED, 32'h0);
    apb(1'b0, MEI_OFF_LINK_MASKED, 32'h0);
    apb(1'b1, MEI_OFF_LINK_MASKED, 32'h1);
    chk_out();
    // completion source: slot 1 enabled, both slots finish
    apb(1'b1, MEI_OFF_EN_SET, 32'h2);
    apb(1'b1, MEI_OFF_ACCESS_GO, 32'h3);
    evt(2'h0, 2'h3);
    chk_out();
    apb(1'b0, MEI_OFF_CMD_RAW, 32'h0);
    apb(1'b0, MEI_OFF_CMD_MASKED, 32'h0);
    apb(1'b1, MEI_OFF_EN_CLEAR, 32'h2);
    apb(1'b0, MEI_OFF_EN_SET, 32'h0);
    // completion and clearing write meet at one edge: the event wins
    apb(1'b1, MEI_OFF_ACCESS_GO, 32'h1);
    fork
      apb(1'b1, MEI_OFF_CMD_RAW, 32'h3);
      begin
        @(posedge pready);
        access_complete <= 2'h1;
        @(posedge sys_clk);
        access_complete <= 2'h0;
      end
    join
    craw |= go & 1;
    cmsk |= go & en & 1;
    go &= ~1;
    apb(1'b0, MEI_OFF_CMD_RAW, 32'h0);
    chk_out();
    // random mix of writes, reads and events
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      idx = r[5:2] % 9;
      case (r[1:0])
        2'h0: apb(1'b1, offs[idx], $random(seed));
        2'h1: apb(1'b0, offs[idx], 32'h0);
        default: evt(r[9:8], r[11:10]);
      endcase
      chk_out();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
